// File: logic/rfr_cfg.svh
`ifndef RFR_CFG_SVH
`define RFR_CFG_SVH
`define RFR_CLK_HZ 20000000
`define RFR_EVAL_US 400
`define RFR_STEP_MS 5
`define RFR_SLOW_MS 100
`define RFR_STABLE_MS 1000
`define RFR_MAX_RETRY 4'he
`define RFR_OFF_CTRL 8'h00
`define RFR_OFF_CMD 8'h04
`define RFR_OFF_STAT 8'h08
`define RFR_OFF_SUM 8'h0c
`define RFR_OFF_UV 8'h10
`define RFR_OFF_OV 8'h14
`define RFR_OFF_GOOD 8'h18
`define RFR_OFF_FILT 8'h1c
`define RFR_OFF_RESP 8'h20
`define RFR_OFF_TIME 8'h24
`define RFR_OFF_STATE 8'h28
`define RFR_CTRL_CONT_BIT 4
`define RFR_CTRL_MAX_LSB 5
`define RFR_CTRL_DLY_LSB 8
`define RFR_HI_LSB 16
`define RFR_FILT_EN_BIT 8
`define RFR_FILT_SLOW_BIT 9
`define RFR_FILT_GPO_BIT 10
`define RFR_SUM_ERR_BIT 31
`define RFR_RST_OV 12'hfff
`define RFR_RST_LO 12'h000
`endif

// File: logic/rfr_pkg.sv
package rfr_pkg;
  typedef enum logic [6:0] {
    RS_OFF = 7'h01, RS_START = 7'h02, RS_ON = 7'h04, RS_DELAY = 7'h08,
    RS_FALL = 7'h10, RS_GAP = 7'h20, RS_HALT = 7'h40
  } rfr_rail_st_t;
  typedef enum logic [4:0] {
    RQ_IDLE = 5'h01, RQ_OFF = 5'h02, RQ_DELAY = 5'h04, RQ_RUN = 5'h08,
    RQ_STOP = 5'h10
  } rfr_rsq_st_t;
  typedef enum logic [1:0] {
    RSP_CONT = 2'h0, RSP_IMM = 2'h1, RSP_DELAY = 2'h2
  } rfr_resp_t;
  typedef enum logic [1:0] {
    RST_NONE = 2'h0, RST_N = 2'h1, RST_CONT = 2'h2
  } rfr_restart_t;
endpackage : rfr_pkg

// File: logic/rfr_top.sv
`timescale 1ns/1ps
`include "rfr_cfg.svh"
module rfr_top #(
  parameter int N_RAILS = 12,
  parameter int EVAL_CYC = (`RFR_CLK_HZ / 1000000) * `RFR_EVAL_US,
  parameter int STEP_CYC = (`RFR_CLK_HZ / 1000) * `RFR_STEP_MS
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion results
  input wire logic adc_valid,
  input wire logic [3:0] adc_sel,
  input wire logic [11:0] adc_data,
  // rails and alert
  input wire logic host_control_pin,
  output logic [N_RAILS-1:0] rail_en,
  output logic alert_out_n,
  output logic warn_gpo
);
  import rfr_pkg::*;
  localparam int EW = $clog2(EVAL_CYC + 1);
  localparam int SW = $clog2(STEP_CYC + 1);
  localparam logic [7:0] STBL = 8'(`RFR_STABLE_MS / `RFR_STEP_MS);
  localparam logic [7:0] SLOW = 8'(`RFR_SLOW_MS / `RFR_STEP_MS);

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a <= `RFR_OFF_STATE);
  endfunction : reg_hit

  // ****************************************
  // time base
  // ****************************************
  logic [EW-1:0] ecnt;
  logic [SW-1:0] scnt;
  logic [7:0] slcnt;
  logic tk_ev, tk_st, slow_pend;
  assign tk_ev = ecnt == EW'(EVAL_CYC - 1);
  assign tk_st = scnt == SW'(STEP_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt <= '0;
      scnt <= '0;
      slcnt <= 8'h00;
      slow_pend <= 1'b0;
    end else begin
      ecnt <= tk_ev ? '0 : EW'(ecnt + 1'b1);
      scnt <= tk_st ? '0 : SW'(scnt + 1'b1);
      if (tk_st) begin
        slcnt <= (slcnt == SLOW - 8'h01) ? 8'h00 : slcnt + 8'h01;
      end
      // slow inputs count one filter step per 100 ms period
      if (tk_st && slcnt == SLOW - 8'h01) begin
        slow_pend <= 1'b1;
      end else if (tk_ev) begin
        slow_pend <= 1'b0;
      end
    end
  end

  // ****************************************
  // register file
  // ****************************************
  logic [11:0] uvw [N_RAILS];
  logic [11:0] uvf [N_RAILS];
  logic [11:0] ovw [N_RAILS];
  logic [11:0] ovf [N_RAILS];
  logic [11:0] gon [N_RAILS];
  logic [11:0] nom [N_RAILS];
  logic [11:0] smp [N_RAILS];
  logic [7:0] flt_t [N_RAILS];
  logic [7:0] gap [N_RAILS];
  logic [7:0] ton [N_RAILS];
  logic [7:0] toff [N_RAILS];
  logic [7:0] tdly [N_RAILS];
  logic [1:0] resp [N_RAILS];
  logic [1:0] rmode [N_RAILS];
  logic [3:0] rn [N_RAILS];
  logic [3:0] tries [N_RAILS];
  logic [5:0] stat [N_RAILS];
  logic [N_RAILS-1:0] slv [N_RAILS];
  rfr_rail_st_t rst [N_RAILS];
  logic [N_RAILS-1:0] flt_en, slow_m, gpo_m, cmd_reg;
  logic [N_RAILS-1:0] req, ign, frc, offd, onst, tofe, anys, wgp;
  logic [3:0] rsel;
  logic cont_err, rs_del, rs_err, err_set, wr, sel_ok;
  logic [1:0] rsmax;
  logic [7:0] rsdly, rcnt;
  logic [2:0] left;
  logic [N_RAILS-1:0] rs_set, rs_org;
  rfr_rsq_st_t rq;
  logic [31:0] rd_c;

  assign wr = psel && penable && pwrite && reg_hit(paddr);
  assign sel_ok = 32'(rsel) < N_RAILS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsel <= 4'h0;
      cont_err <= 1'b0;
      rsmax <= 2'h0;
      rsdly <= 8'h00;
      cmd_reg <= '0;
      flt_en <= '0;
      slow_m <= '0;
      gpo_m <= '0;
      for (int i = 0; i < N_RAILS; i++) begin
        uvw[i] <= `RFR_RST_LO;
        uvf[i] <= `RFR_RST_LO;
        ovw[i] <= `RFR_RST_OV;
        ovf[i] <= `RFR_RST_OV;
        gon[i] <= `RFR_RST_LO;
        nom[i] <= `RFR_RST_LO;
        flt_t[i] <= 8'h00;
        gap[i] <= 8'h00;
        ton[i] <= 8'h00;
        toff[i] <= 8'h00;
        tdly[i] <= 8'h00;
        resp[i] <= RSP_CONT;
        rmode[i] <= RST_NONE;
        rn[i] <= 4'h0;
        slv[i] <= '0;
      end
    end else if (wr) begin
      if (paddr == `RFR_OFF_CTRL) begin
        rsel <= pwdata[3:0];
        cont_err <= pwdata[`RFR_CTRL_CONT_BIT];
        rsmax <= pwdata[`RFR_CTRL_MAX_LSB +: 2];
        rsdly <= pwdata[`RFR_CTRL_DLY_LSB +: 8];
      end else if (paddr == `RFR_OFF_CMD) begin
        cmd_reg <= pwdata[N_RAILS-1:0];
      end else if (sel_ok) begin
        unique case (paddr)
          `RFR_OFF_UV: begin
            uvw[rsel] <= pwdata[11:0];
            uvf[rsel] <= pwdata[`RFR_HI_LSB +: 12];
          end
          `RFR_OFF_OV: begin
            ovw[rsel] <= pwdata[11:0];
            ovf[rsel] <= pwdata[`RFR_HI_LSB +: 12];
          end
          `RFR_OFF_GOOD: begin
            gon[rsel] <= pwdata[11:0];
            nom[rsel] <= pwdata[`RFR_HI_LSB +: 12];
          end
          `RFR_OFF_FILT: begin
            flt_t[rsel] <= pwdata[7:0];
            flt_en[rsel] <= pwdata[`RFR_FILT_EN_BIT];
            slow_m[rsel] <= pwdata[`RFR_FILT_SLOW_BIT];
            gpo_m[rsel] <= pwdata[`RFR_FILT_GPO_BIT];
          end
          `RFR_OFF_RESP: begin
            resp[rsel] <= pwdata[1:0];
            rmode[rsel] <= pwdata[3:2];
            // larger counts saturate at the documented ceiling
            rn[rsel] <= (pwdata[7:4] > `RFR_MAX_RETRY) ? `RFR_MAX_RETRY
                                                        : pwdata[7:4];
            gap[rsel] <= pwdata[15:8];
            slv[rsel] <= pwdata[`RFR_HI_LSB +: N_RAILS];
          end
          `RFR_OFF_TIME: begin
            ton[rsel] <= pwdata[7:0];
            toff[rsel] <= pwdata[15:8];
            tdly[rsel] <= pwdata[23:16];
          end
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    rd_c = 32'h0000_0000;
    if (paddr == `RFR_OFF_CTRL) begin
      rd_c[3:0] = rsel;
      rd_c[`RFR_CTRL_CONT_BIT] = cont_err;
      rd_c[`RFR_CTRL_MAX_LSB +: 2] = rsmax;
      rd_c[`RFR_CTRL_DLY_LSB +: 8] = rsdly;
    end else if (paddr == `RFR_OFF_CMD) begin
      rd_c[N_RAILS-1:0] = cmd_reg;
    end else if (paddr == `RFR_OFF_SUM) begin
      rd_c[N_RAILS-1:0] = anys;
      rd_c[`RFR_SUM_ERR_BIT] = rs_err;
    end else if (sel_ok) begin
      unique case (paddr)
        `RFR_OFF_STAT: rd_c[5:0] = stat[rsel];
        `RFR_OFF_UV: rd_c = {4'h0, uvf[rsel], 4'h0, uvw[rsel]};
        `RFR_OFF_OV: rd_c = {4'h0, ovf[rsel], 4'h0, ovw[rsel]};
        `RFR_OFF_GOOD: rd_c = {4'h0, nom[rsel], 4'h0, gon[rsel]};
        `RFR_OFF_FILT: rd_c[10:0] = {gpo_m[rsel], slow_m[rsel],
                                     flt_en[rsel], flt_t[rsel]};
        `RFR_OFF_RESP: begin
          rd_c[15:0] = {gap[rsel], rn[rsel], rmode[rsel], resp[rsel]};
          rd_c[`RFR_HI_LSB +: N_RAILS] = slv[rsel];
        end
        `RFR_OFF_TIME: rd_c[23:0] = {tdly[rsel], toff[rsel], ton[rsel]};
        `RFR_OFF_STATE: rd_c[26:0] = {left, 3'h0, rq, 4'h0, tries[rsel],
                                      1'b0, rst[rsel]};
        default: ;
      endcase
    end
  end

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_c;
    end
  end

  // ****************************************
  // per-rail supervision
  // ****************************************
  for (genvar gi = 0; gi < N_RAILS; gi++) begin : g_rail
    logic [8:0] fc [4];
    logic [8:0] lim;
    logic [3:0] raw, fire;
    logic [7:0] tl, tmr;
    logic [5:0] clr;
    logic ev, hit, below, ton_f, flt, rt_ok, want, go_dn, pg, retry, halt;
    rfr_rail_st_t nx;

    assign ev = tk_ev && (!slow_m[gi] || slow_pend);
    assign lim = flt_en[gi] ? {1'b0, flt_t[gi]} : 9'h000;
    assign raw[0] = pg && (smp[gi] < uvw[gi]);
    assign raw[1] = pg && (smp[gi] < uvf[gi]);
    assign raw[2] = smp[gi] > ovw[gi];
    assign raw[3] = smp[gi] > ovf[gi];
    assign below = smp[gi] < {3'h0, nom[gi][11:3]};
    assign hit = tmr >= tl;
    assign ton_f = rst[gi] == RS_START && tk_st && hit && !ign[gi];
    assign tofe[gi] = rst[gi] == RS_FALL && tk_st && hit;
    assign flt = fire[1] || fire[3] || ton_f;
    assign rt_ok = rmode[gi] == RST_CONT ||
                   (rmode[gi] == RST_N && tries[gi] < rn[gi]);
    assign want = cmd_reg[gi] && host_control_pin && !frc[gi];
    assign go_dn = flt && resp[gi] != RSP_CONT &&
                   (rst[gi] == RS_START || rst[gi] == RS_ON);
    // set handed to re-sequencing only once retries are spent
    assign req[gi] = go_dn && !rt_ok && (|slv[gi]);
    assign offd[gi] = rst[gi] == RS_OFF || rst[gi] == RS_HALT ||
                      rst[gi] == RS_GAP;
    assign onst[gi] = rst[gi] == RS_ON;
    assign anys[gi] = |stat[gi];
    assign wgp[gi] = gpo_m[gi] && (stat[gi][0] || stat[gi][2]);
    assign clr = (wr && paddr == `RFR_OFF_STAT && rsel == 4'(gi))
                 ? pwdata[5:0] : 6'h00;

    for (genvar k = 0; k < 4; k++) begin : g_cond
      // event fires once, on the evaluation that completes the filter time
      assign fire[k] = ev && raw[k] && fc[k] == lim && !ign[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fc[k] <= 9'h000;
        end else if (ev) begin
          if (!raw[k]) begin
            fc[k] <= 9'h000;
          end else if (fc[k] != 9'(lim + 9'h001)) begin
            fc[k] <= 9'(fc[k] + 9'h001);
          end
        end
      end
    end

    always_comb begin
      unique case (rst[gi])
        RS_START: tl = ton[gi];
        RS_DELAY: tl = tdly[gi];
        RS_FALL: tl = toff[gi];
        RS_GAP: tl = gap[gi];
        default: tl = 8'hff;
      endcase
    end

    always_comb begin
      nx = rst[gi];
      unique case (rst[gi])
        RS_OFF: if (want) nx = RS_START;
        RS_START, RS_ON: begin
          if (go_dn) begin
            // retries always drop the rail at once
            nx = (rt_ok || resp[gi] != RSP_DELAY) ? RS_FALL : RS_DELAY;
          end else if (!want) begin
            nx = (frc[gi] && !rs_del) ? RS_FALL : RS_DELAY;
          end else if (rst[gi] == RS_START && ev && smp[gi] >= gon[gi]) begin
            nx = RS_ON;
          end
        end
        RS_DELAY: if (tk_st && hit) nx = RS_FALL;
        RS_FALL: if ((ev && below) || tofe[gi]) begin
          nx = retry ? RS_GAP : (halt && !rs_set[gi]) ? RS_HALT : RS_OFF;
        end
        RS_GAP: begin
          if (!(cmd_reg[gi] && host_control_pin)) nx = RS_OFF;
          else if (tk_st && hit) nx = RS_START;
        end
        RS_HALT: if (!cmd_reg[gi]) nx = RS_OFF;
        default: nx = RS_OFF;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rst[gi] <= RS_OFF;
        rail_en[gi] <= 1'b0;
        tmr <= 8'h00;
        pg <= 1'b0;
        retry <= 1'b0;
        halt <= 1'b0;
        tries[gi] <= 4'h0;
        smp[gi] <= 12'h000;
      end else begin
        rst[gi] <= nx;
        rail_en[gi] <= nx == RS_START || nx == RS_ON || nx == RS_DELAY;
        tmr <= (nx != rst[gi] && nx != RS_GAP) ? 8'h00 :
               (tk_st && tmr != 8'hff) ? tmr + 8'h01 : tmr;
        if (adc_valid && adc_sel == 4'(gi)) smp[gi] <= adc_data;
        if (rst[gi] == RS_START && nx == RS_ON) pg <= 1'b1;
        else if (nx == RS_FALL) pg <= 1'b0;
        if (rst[gi] == RS_START || rst[gi] == RS_ON) begin
          retry <= go_dn && rt_ok;
          halt <= go_dn && !rt_ok;
        end
        if (go_dn && rt_ok && rmode[gi] == RST_N) begin
          tries[gi] <= tries[gi] + 4'h1;
        end else if (!cmd_reg[gi] && (offd[gi] || rst[gi] == RS_FALL)) begin
          tries[gi] <= 4'h0;
        end
      end
    end

    // sticky status; a new event in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stat[gi] <= 6'h00;
      end else begin
        stat[gi] <= (stat[gi] & ~clr) | {tofe[gi], ton_f, fire};
      end
    end
  end

  // ****************************************
  // re-sequencing
  // ****************************************
  logic [N_RAILS-1:0] nmask;
  logic ndel, all_off, all_on, rs_busy;
  always_comb begin
    nmask = '0;
    ndel = 1'b1;
    for (int i = 0; i < N_RAILS; i++) begin
      if (req[i]) begin
        nmask = nmask | slv[i];
        nmask[i] = 1'b1;
        ndel = ndel && resp[i] == RSP_DELAY;
      end
    end
  end
  assign rs_busy = rq != RQ_IDLE;
  assign ign = rs_busy ? (rs_set & ~rs_org) : '0;
  assign frc = (rq == RQ_OFF || rq == RQ_DELAY || rq == RQ_STOP) ? rs_set
                                                                  : '0;
  assign all_off = &(~rs_set | offd);
  assign all_on = &(~rs_set | onst);
  assign err_set = (rq == RQ_OFF && (|(tofe & rs_set))) ||
                   ((|req) && rq == RQ_RUN && left == 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq <= RQ_IDLE;
      rs_set <= '0;
      rs_org <= '0;
      rs_del <= 1'b1;
      left <= 3'h0;
      rcnt <= 8'h00;
    end else if (|req) begin
      rs_set <= rs_set | nmask;
      rs_org <= rs_org | req;
      rs_del <= (rs_busy ? rs_del : 1'b1) && ndel;
      rcnt <= 8'h00;
      if (!rs_busy) begin
        left <= {1'b0, rsmax} + 3'h1;
        rq <= RQ_OFF;
      end else if (rq == RQ_RUN || rq == RQ_DELAY) begin
        rq <= (rq == RQ_RUN && left == 3'h0) ? RQ_STOP : RQ_OFF;
      end
    end else begin
      unique case (rq)
        RQ_OFF: begin
          if ((|(tofe & rs_set)) && !cont_err) rq <= RQ_STOP;
          else if (all_off) rq <= RQ_DELAY;
        end
        RQ_DELAY: if (tk_st) begin
          if (rcnt >= rsdly) begin
            rq <= RQ_RUN;
            left <= left - 3'h1;
            rcnt <= 8'h00;
          end else begin
            rcnt <= rcnt + 8'h01;
          end
        end
        RQ_RUN: begin
          if (!all_on) begin
            rcnt <= 8'h00;
          end else if (tk_st) begin
            rcnt <= rcnt + 8'h01;
            if (rcnt == STBL - 8'h01) begin
              rq <= RQ_IDLE;
              rs_set <= '0;
              rs_org <= '0;
            end
          end
        end
        RQ_STOP: if (!rs_err) begin
          // rails stay forced off until software clears the error
          rq <= RQ_IDLE;
          rs_set <= '0;
          rs_org <= '0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_err <= 1'b0;
    end else begin
      rs_err <= (rs_err && !(wr && paddr == `RFR_OFF_SUM &&
                 pwdata[`RFR_SUM_ERR_BIT])) || err_set;
    end
  end

  // ****************************************
  // alert and warning output
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_out_n <= 1'b1;
      warn_gpo <= 1'b0;
    end else begin
      alert_out_n <= !((|anys) || rs_err);
      warn_gpo <= |wgp;
    end
  end
endmodule : rfr_top

// File: verif/rfr_asserts.sv
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module rfr_asserts #(
  parameter int N_RAILS = 12
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // rails and alert
  input wire logic host_control_pin,
  input wire logic [N_RAILS-1:0] rail_en,
  input wire logic alert_out_n,
  input wire logic warn_gpo
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] clr_cnt;
  // edges since the last status clear; outputs lag it by a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_cnt <= 8'hff;
    else if (psel && penable && pwrite && paddr inside {8'h08, 8'h0c})
      clr_cnt <= 8'h00;
    else if (clr_cnt != 8'hff) clr_cnt <= clr_cnt + 8'h01;
  end
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd_err;
    s_acc ##0 (!pwrite && pslverr);
  endsequence
  property p_ready;
    s_acc |-> pready;
  endproperty
  property p_err;
    pslverr == (psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h28));
  endproperty
  property p_rd_zero;
    s_rd_err |-> prdata == 32'h0;
  endproperty
  property p_rst_out;
    $rose(presetn) |-> alert_out_n && !warn_gpo && rail_en == '0;
  endproperty
  property p_rail_pin;
    |(rail_en & ~$past(rail_en)) |-> $past(host_control_pin);
  endproperty
  property p_alert_clr;
    $rose(alert_out_n) |-> clr_cnt <= 8'h03;
  endproperty
  property p_gpo_clr;
    $fell(warn_gpo) |-> clr_cnt <= 8'h03;
  endproperty
  property p_gpo_alert;
    $rose(warn_gpo) |-> ##[0:1] !alert_out_n;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("bad pslverr");
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read data");
  a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
  a_rail_pin: assert property (p_rail_pin) else $error("rail on, pin low");
  a_alert_clr: assert property (p_alert_clr) else $error("alert freed");
  a_gpo_clr: assert property (p_gpo_clr) else $error("gpo freed");
  a_gpo_alert: assert property (p_gpo_alert) else $error("gpo, no alert");
endmodule : rfr_asserts
bind rfr_top rfr_asserts #(.N_RAILS(N_RAILS)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .host_control_pin(host_control_pin),
  .rail_en(rail_en), .alert_out_n(alert_out_n), .warn_gpo(warn_gpo)
);

// File: verif/rfr_rail_model.sv
`timescale 1ns/1ps
// ********************
// supply rails behind the converter
// ********************
module rfr_rail_model #(
  parameter int N_RAILS = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enables and test controls
  input wire logic [N_RAILS-1:0] rail_en,
  input wire logic [11:0] v_on,
  input wire logic [11:0] ramp,
  input wire logic force_on,
  input wire logic [11:0] force_val,
  // conversion results
  output logic adc_valid,
  output logic [3:0] adc_sel,
  output logic [11:0] adc_data
);
  logic [11:0] volt [N_RAILS];
  logic [3:0] sel_reg;
  logic [12:0] up;
  assign up = {1'b0, volt[sel_reg]} + {1'b0, ramp};
  // a disabled rail collapses at once, so no turn-off limit trips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= 4'h0;
      adc_valid <= 1'b0;
      adc_sel <= 4'h0;
      adc_data <= 12'h000;
      for (int i = 0; i < N_RAILS; i++) volt[i] <= 12'h000;
    end else if (!adc_valid) begin
      adc_valid <= 1'b1;
      adc_sel <= sel_reg;
      sel_reg <= (sel_reg == 4'(N_RAILS - 1)) ? 4'h0 : sel_reg + 4'h1;
      if (!rail_en[sel_reg]) begin
        volt[sel_reg] <= 12'h000;
        adc_data <= 12'h000;
      end else if (force_on) begin
        adc_data <= force_val;
      end else begin
        volt[sel_reg] <= (up > {1'b0, v_on}) ? v_on : up[11:0];
        adc_data <= (up > {1'b0, v_on}) ? v_on : up[11:0];
      end
    end else begin
      // between results the lines carry junk, never the last value
      adc_valid <= 1'b0;
      adc_sel <= ~adc_sel;
      adc_data <= ~adc_data;
    end
  end
endmodule : rfr_rail_model

// File: verif/tb_rail_fault_response.sv
`timescale 1ns/1ps
// ********************
// bench
// ********************
module tb_rail_fault_response;
  import rfr_pkg::*;
  localparam int EV = 20;
  localparam int ST = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic host_control_pin = 1'b1;
  logic [11:0] v_on = 12'h900;
  logic [11:0] ramp = 12'h100;
  logic force_on = 1'b0;
  logic [11:0] force_val = 12'h400;
  logic [31:0] prdata, d;
  logic [11:0] rail_en, adc_data;
  logic [3:0] adc_sel;
  logic pready, pslverr, adc_valid, alert_out_n, warn_gpo, e;
  int failures = 0;
  int n_tests = 0;
  always #25 pclk = ~pclk;
  rfr_top #(.EVAL_CYC(EV), .STEP_CYC(ST)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid),
    .adc_sel(adc_sel), .adc_data(adc_data),
    .host_control_pin(host_control_pin), .rail_en(rail_en),
    .alert_out_n(alert_out_n), .warn_gpo(warn_gpo));
  rfr_rail_model u_model (
    .pclk(pclk), .presetn(presetn), .rail_en(rail_en), .v_on(v_on),
    .ramp(ramp), .force_on(force_on), .force_val(force_val),
    .adc_valid(adc_valid), .adc_sel(adc_sel), .adc_data(adc_data));
  task automatic finish_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    chk(i < 16, 1'b1, "pready wait");
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_alert(input int lim, output int n);
    for (n = 0; n < lim && alert_out_n !== 1'b0; n++) @(posedge pclk);
    chk(n < lim, 1'b1, "alert wait");
  endtask : wait_alert
  task automatic wait_on;
    int i;
    d = 32'h0;
    for (i = 0; i < 300 && d[6:0] !== 7'h04; i++) apb(1'b1 ^ 1'b1, 8'h28, 0);
    chk(i < 300, 1'b1, "rail on");
  endtask : wait_on
  // one rail: limits, nominal 0x800, turn-off limit at its maximum
  task automatic cfg(input logic [3:0] r, input logic [31:0] ov, uv, filt,
      resp, input logic [11:0] good, input logic [7:0] on_lim);
    apb(1'b1, 8'h00, {28'h0, r});
    apb(1'b1, 8'h10, uv);
    apb(1'b1, 8'h14, ov);
    apb(1'b1, 8'h18, {20'h08000, good});
    apb(1'b1, 8'h1c, filt);
    apb(1'b1, 8'h20, resp);
    apb(1'b1, 8'h24, {16'h00ff, on_lim});
  endtask : cfg
  task automatic s_ov;
    int n;
    cfg(4'h0, 32'h0fff0800, 32'h0, 32'h400, 32'h0, 12'h000, 8'hff);
    apb(1'b1, 8'h04, 32'h1);
    wait_alert(40 * EV, n);
    apb(1'b0, 8'h08, 32'h0);
    chk(d & 32'h3f, 32'h4, "ov warn status");
    chk({warn_gpo, rail_en[0]}, 2'b11, "gpo, rail kept");
    host_control_pin <= 1'b0;
    repeat (3 * ST) @(posedge pclk);
    chk({alert_out_n, rail_en[0]}, 2'b00, "pin off, alert held");
    apb(1'b1, 8'h04, 32'h0);
    host_control_pin <= 1'b1;
    apb(1'b1, 8'h08, 32'h3f);
    repeat (3) @(posedge pclk);
    chk({alert_out_n, warn_gpo}, 2'b10, "cleared");
  endtask : s_ov
  task automatic s_uv;
    int n;
    ramp <= 12'h080;
    cfg(4'h1, 32'h0fff0fff, 32'h03000500, 32'h0, 32'h0, 12'h600, 8'hff);
    apb(1'b1, 8'h04, 32'h2);
    wait_on();
    apb(1'b0, 8'h08, 32'h0);
    chk(d & 32'h3f, 32'h0, "no uv in ramp");
    force_on <= 1'b1;
    wait_alert(4 * EV, n);
    apb(1'b0, 8'h08, 32'h0);
    chk(d & 32'h3f, 32'h1, "uv warn only");
    force_val <= 12'h200;
    repeat (4 * EV) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk({d[5:0], rail_en[1]}, 7'h07, "uv fault, continue");
    force_on <= 1'b0;
    repeat (2 * EV) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h3f);
    apb(1'b1, 8'h04, 32'h0);
  endtask : s_uv
  task automatic s_filt;
    int n;
    ramp <= 12'hfff;
    force_val <= 12'hc00;
    cfg(4'h2, 32'h0fff0a00, 32'h0, 32'h103, 32'h0, 12'h000, 8'hff);
    apb(1'b1, 8'h04, 32'h4);
    wait_on();
    force_on <= 1'b1;
    repeat (24) @(posedge pclk);
    force_on <= 1'b0;
    repeat (6 * EV) @(posedge pclk);
    chk(alert_out_n, 1'b1, "short glitch");
    force_on <= 1'b1;
    wait_alert(8 * EV, n);
    chk(n >= 3 * EV, 1'b1, "filter time");
    force_on <= 1'b0;
    repeat (2 * EV) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h3f);
    apb(1'b1, 8'h04, 32'h0);
  endtask : s_filt
  task automatic s_restart(input logic [1:0] mode, input int tries);
    int ons;
    int gap;
    logic was;
    ons = 0;
    gap = 0;
    was = 1'b0;
    cfg(4'h3, 32'h08000fff, 32'h0, 32'h0, {16'h0, 8'h06, 4'(tries), mode,
        2'h1}, 12'h000, 8'hff);
    apb(1'b1, 8'h04, 32'h8);
    repeat (1500) begin
      @(posedge pclk);
      if (rail_en[3] === 1'b1 && !was && ons > 0)
        chk(gap >= 6 * ST && gap <= 7 * ST + 2, 1'b1, "gap");
      if (rail_en[3] === 1'b1 && !was) ons++;
      gap = rail_en[3] ? 0 : gap + 1;
      was = rail_en[3];
    end
    chk(ons, tries + 1, "enable pulses");
    apb(1'b0, 8'h28, 32'h0);
    chk({d[11:8], rail_en[3]}, {4'(tries), 1'b0}, "retries, off");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h3f);
  endtask : s_restart
  // rail 4 always faults; rail 5 is its slave; two attempts, then error
  task automatic s_reseq;
    int ons;
    logic was;
    ons = 0;
    was = 1'b0;
    cfg(4'h5, 32'h0fff0fff, 32'h0, 32'h0, 32'h0, 12'h000, 8'hff);
    cfg(4'h4, 32'h08000fff, 32'h0, 32'h0, 32'h00200001, 12'h000, 8'hff);
    apb(1'b1, 8'h00, 32'h0124);
    apb(1'b1, 8'h04, 32'h30);
    repeat (1500) begin
      @(posedge pclk);
      if (rail_en[5] === 1'b1 && !was) ons++;
      was = rail_en[5];
    end
    chk(ons, 3, "slave re-sequenced");
    apb(1'b0, 8'h0c, 32'h0);
    chk({d[31], d[5:4], rail_en[5:4]}, 5'b10100, "held off");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h0c, 32'h80000000);
    apb(1'b1, 8'h08, 32'h3f);
  endtask : s_reseq
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0);
    chk(d, 32'h0fff0fff, "ov reset");
    apb(1'b0, 8'h2c, 32'h0);
    chk({e, d[30:0]}, 32'h80000000, "unmapped");
    s_ov();
    s_uv();
    s_filt();
    s_restart(2'h0, 0);
    s_restart(2'h1, 2);
    s_reseq();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule : tb_rail_fault_response
